// ==== tesc_pkg.sv ====
`default_nettype none
package tesc_pkg;
  localparam int CNT_W = 16;
  localparam int NCH = 2;
  // Event action encodings
  localparam logic [2:0] EVA_OFF = 3'h0;
  localparam logic [2:0] EVA_START = 3'h1;
  localparam logic [2:0] EVA_RETRIG = 3'h2;
  localparam logic [2:0] EVA_COUNT = 3'h3;
  localparam logic [2:0] EVA_STAMP = 3'h4;
  localparam logic [2:0] EVA_PPW = 3'h5;
  localparam logic [2:0] EVA_PWP = 3'h6;
  localparam logic [2:0] EVA_PW = 3'h7;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [1:0] SYNC_STAGES = 2'h2;
  typedef struct packed {
    logic [2:0] event_action_select;
    logic input_event_enable;
    logic [NCH-1:0] channel_output_event_enable;
    logic run_in_standby;
    logic clock_on_demand;
  } tesc_cfg_t;
  typedef enum logic [2:0] {
    ST_STOP = 3'b001,
    ST_REQ = 3'b010,
    ST_RUN = 3'b100
  } tesc_state_t;
endpackage : tesc_pkg
`default_nettype wire

// ==== tesc_timer.sv ====
// Overview of operation
// - Period/width capture takes two captures and restarts counter on one edge.
// - Per-channel output event enable gates that channel's output event.
// - Event action select picks one input-event behaviour among eight.
// - Input events are ignored while input event enable is zero.
// - In standby the timer runs only with run in standby set.
// - Events and captures continue during standby only with run in standby set.
// - On demand mode drops clock request while stopped.
// - On demand start raises request and counts only once clock ready.
// - Soft reset, enable and buffer valid writes cross before taking effect.
// - Control, count, period and channel writes cross before taking effect.
// - Read sync command copies live count into readable register.
// - Capture while flag and buffer valid set discards timestamp and sets error flag.
// - Channel buffer feeds value register when empty or just read.
`default_nettype none
module tesc_timer (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire tesc_pkg::tesc_cfg_t i_cfg,
  input wire logic i_standby,
  input wire logic i_clk_ready,
  input wire logic i_event,
  input wire logic i_wr_soft_reset_bit,
  input wire logic i_wr_enable,
  input wire logic i_enable_val,
  input wire logic i_wr_stop_cmd,
  input wire logic i_wr_read_sync_command,
  input wire logic i_wr_count,
  input wire logic i_wr_per,
  input wire logic [tesc_pkg::CNT_W-1:0] i_wdata,
  input wire logic [tesc_pkg::NCH-1:0] i_wr_bufv_clr,
  input wire logic [tesc_pkg::NCH-1:0] i_rd_cc,
  output logic o_clk_req,
  output logic o_stopped,
  output logic o_running,
  output logic [tesc_pkg::CNT_W-1:0] o_count_rd,
  output logic [tesc_pkg::CNT_W-1:0] o_per,
  output logic [tesc_pkg::NCH*tesc_pkg::CNT_W-1:0] o_cc,
  output logic [tesc_pkg::NCH-1:0] o_cc_flag,
  output logic [tesc_pkg::NCH-1:0] o_cc_bufv,
  output logic [tesc_pkg::NCH-1:0] o_err,
  output logic [tesc_pkg::NCH-1:0] o_out_event,
  output logic [5:0] o_sync_busy
);
  localparam int W = tesc_pkg::CNT_W;
  localparam int N = tesc_pkg::NCH;

  ////////////////////////////////////////////////////////////////////////////
  // Write crossing: two-stage pipe per item, busy until the last stage
  logic [5:0] req_q, s1_q, s2_q;
  logic [5:0] wr_req;
  logic [W-1:0] wdata_q;
  assign wr_req = {i_wr_per, i_wr_count, i_wr_read_sync_command, i_wr_stop_cmd, i_wr_enable,
                   i_wr_soft_reset_bit};
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_q <= 6'h00;
      s2_q <= 6'h00;
      wdata_q <= tesc_pkg::CNT_RESET;
    end else if (i_ce) begin
      s1_q <= wr_req;
      s2_q <= s1_q;
      if (i_wr_count || i_wr_per) begin
        wdata_q <= i_wdata;
      end
    end
  end
  assign req_q = s2_q;
  logic [N-1:0] bufv_clr_s1_q, bufv_clr_s2_q;
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bufv_clr_s1_q <= '0;
      bufv_clr_s2_q <= '0;
    end else if (i_ce) begin
      bufv_clr_s1_q <= i_wr_bufv_clr;
      bufv_clr_s2_q <= bufv_clr_s1_q;
    end
  end
  // busy per item
  // Busy follows the pipe itself, so a write right behind another keeps it up
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sync_busy <= 6'h00;
    end else if (i_ce) begin
      o_sync_busy <= wr_req | s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter control and clock request
  tesc_pkg::tesc_state_t st_q;
  logic enable_q, ev_q, ev_d, rd_pend_q;
  logic [W-1:0] cnt_q;
  logic phase_q;
  logic soft_reset_bit;
  logic active;
  logic trig;
  logic en_rise;
  assign soft_reset_bit = req_q[0];
  // Enable lands this cycle; enable_q still shows the old value here
  assign en_rise = req_q[1] && i_enable_val && !enable_q &&
                   (!i_standby || i_cfg.run_in_standby);
  assign ev_d = i_event && i_cfg.input_event_enable && enable_q;
  assign active = enable_q && (!i_standby || i_cfg.run_in_standby);
  assign trig = ev_q && (i_cfg.event_action_select == tesc_pkg::EVA_START ||
                         i_cfg.event_action_select == tesc_pkg::EVA_RETRIG);
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      enable_q <= 1'b0;
      ev_q <= 1'b0;
    end else if (i_ce) begin
      ev_q <= ev_d && !soft_reset_bit;
      if (soft_reset_bit) begin
        enable_q <= 1'b0;
      end else if (req_q[1]) begin
        enable_q <= i_enable_val;
      end
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= tesc_pkg::ST_STOP;
    end else if (i_ce) begin
      unique case (st_q)
        tesc_pkg::ST_STOP: begin
          if (!soft_reset_bit && ((active && trig) || (en_rise &&
              i_cfg.event_action_select != tesc_pkg::EVA_START))) begin
            st_q <= tesc_pkg::ST_REQ;
          end
        end
        tesc_pkg::ST_REQ: begin
          if (!active || soft_reset_bit) begin
            st_q <= tesc_pkg::ST_STOP;
          end else if (i_clk_ready || !i_cfg.clock_on_demand) begin
            st_q <= tesc_pkg::ST_RUN;
          end
        end
        tesc_pkg::ST_RUN: begin
          if (!active || soft_reset_bit || req_q[2]) begin
            st_q <= tesc_pkg::ST_STOP;
          end
        end
        default: st_q <= tesc_pkg::ST_STOP;
      endcase
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_clk_req <= 1'b0;
      o_stopped <= 1'b1;
      o_running <= 1'b0;
    end else if (i_ce) begin
      o_stopped <= (st_q == tesc_pkg::ST_STOP);
      o_running <= (st_q == tesc_pkg::ST_RUN);
      o_clk_req <= !i_cfg.clock_on_demand || (st_q != tesc_pkg::ST_STOP);
    end
  end
  logic run;
  logic restart;
  assign run = (st_q == tesc_pkg::ST_RUN);
  assign restart = ev_q && ((i_cfg.event_action_select == tesc_pkg::EVA_RETRIG) ||
    (i_cfg.event_action_select == tesc_pkg::EVA_PPW && !phase_q) ||
    (i_cfg.event_action_select == tesc_pkg::EVA_PWP && phase_q) ||
    (i_cfg.event_action_select == tesc_pkg::EVA_PW && !phase_q));
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= tesc_pkg::CNT_RESET;
      phase_q <= 1'b0;
    end else if (i_ce) begin
      if (soft_reset_bit) begin
        cnt_q <= tesc_pkg::CNT_RESET;
        phase_q <= 1'b0;
      end else if (req_q[4]) begin
        cnt_q <= wdata_q;
      end else if (run) begin
        if (restart) begin
          cnt_q <= tesc_pkg::CNT_RESET;
        end else if (i_cfg.event_action_select == tesc_pkg::EVA_COUNT) begin
          cnt_q <= cnt_q + W'(ev_q);
        end else begin
          cnt_q <= cnt_q + W'(1);
        end
        if (ev_q) begin
          phase_q <= !phase_q;
        end
      end
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_count_rd <= tesc_pkg::CNT_RESET;
      o_per <= {W{1'b1}};
      rd_pend_q <= 1'b0;
    end else if (i_ce) begin
      rd_pend_q <= req_q[3];
      if (soft_reset_bit) begin
        o_count_rd <= tesc_pkg::CNT_RESET;
        o_per <= {W{1'b1}};
      end else begin
        if (req_q[3]) begin
          o_count_rd <= cnt_q;
        end
        if (req_q[5]) begin
          o_per <= wdata_q;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture channels
  logic capt_mode;
  assign capt_mode = i_cfg.event_action_select >= tesc_pkg::EVA_STAMP;
  for (genvar c = 0; c < N; c++) begin : g_ch
    logic [W-1:0] buf_q;
    logic take;
    // Channel 0 takes stamps and one capture edge; channel 1 the other edge
    assign take = run && capt_mode && ev_q &&
      ((i_cfg.event_action_select == tesc_pkg::EVA_STAMP) ? (c == 0) :
       (phase_q == (c == 1)));
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        buf_q <= tesc_pkg::CNT_RESET;
        o_cc[c*W +: W] <= tesc_pkg::CNT_RESET;
        o_cc_flag[c] <= 1'b0;
        o_cc_bufv[c] <= 1'b0;
        o_err[c] <= 1'b0;
        o_out_event[c] <= 1'b0;
      end else if (i_ce) begin
        if (soft_reset_bit) begin
          buf_q <= tesc_pkg::CNT_RESET;
          o_cc[c*W +: W] <= tesc_pkg::CNT_RESET;
          o_cc_flag[c] <= 1'b0;
          o_cc_bufv[c] <= 1'b0;
          o_err[c] <= 1'b0;
          o_out_event[c] <= 1'b0;
        end else begin
          o_out_event[c] <= take && !o_cc_flag[c] &&
                            i_cfg.channel_output_event_enable[c];
          if (take && o_cc_flag[c] && o_cc_bufv[c] && !i_rd_cc[c]) begin
            o_err[c] <= 1'b1;
          end
          if ((!o_cc_flag[c] || i_rd_cc[c]) && o_cc_bufv[c]) begin
            o_cc[c*W +: W] <= buf_q;
            o_cc_flag[c] <= 1'b1;
            o_cc_bufv[c] <= take;
            if (take) begin
              buf_q <= cnt_q;
            end
          end else if (take && (!o_cc_flag[c] || i_rd_cc[c])) begin
            o_cc[c*W +: W] <= cnt_q;
            o_cc_flag[c] <= 1'b1;
          end else begin
            if (i_rd_cc[c]) begin
              o_cc_flag[c] <= 1'b0;
            end
            // Value register full: a new capture parks in the buffer; set beats clear
            if (take && !o_cc_bufv[c]) begin
              buf_q <= cnt_q;
              o_cc_bufv[c] <= 1'b1;
            end else if (bufv_clr_s2_q[c]) begin
              o_cc_bufv[c] <= 1'b0;
            end
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // stopped in on-demand mode means no request
  AST_CLOCK_ON_DEMAND_REQ: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_ce && i_cfg.clock_on_demand && st_q == tesc_pkg::ST_STOP && $stable(i_cfg)
    |=> !o_clk_req || !i_ce) else $error("clock request held while stopped");
  AST_RUN_AFTER_REQ: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    $rose(run) |-> $past(st_q) == tesc_pkg::ST_REQ) else $error("run without request");
  AST_SYNC_BUSY: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_ce && i_wr_enable |=> o_sync_busy[1]) else $error("busy not shown");
  AST_SOFT_RESET_BIT: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_ce && soft_reset_bit |=> !enable_q && cnt_q == tesc_pkg::CNT_RESET)
    else $error("soft reset incomplete");
  AST_EV_GATE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_ce && !i_cfg.input_event_enable |=> !ev_q) else $error("event not gated");
  AST_OUT_EV: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_out_event[0] |-> $past(i_cfg.channel_output_event_enable[0]))
    else $error("output event while disabled");
  AST_ERR: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_ce && !soft_reset_bit && g_ch[0].take && o_cc_flag[0] && o_cc_bufv[0] && !i_rd_cc[0]
    |=> o_err[0])
    else $error("overflow not flagged");
  AST_READ_SYNC_COMMAND: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_ce && req_q[3] && !soft_reset_bit |=> o_count_rd == $past(cnt_q))
    else $error("read sync copy wrong");
endmodule : tesc_timer
`default_nettype wire

// ==== tesc_evsys_model.sv ====
`default_nettype none
module tesc_evsys_model (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_req,
  input wire logic i_fire,
  input wire logic [3:0] i_ready_lag,
  output logic o_event,
  output logic o_clk_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] lag_q;
  // async event path
  // Skewed off the timer edge, as the router path has its own delay
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) o_event <= 1'h0;
    else o_event <= #2 i_fire;
  end
  // Clock grant lags the request; a slow lag exercises the wait state
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lag_q <= 4'h0;
      o_clk_ready <= 1'h0;
    end else if (!i_clk_req) begin
      lag_q <= 4'h0;
      o_clk_ready <= #1 1'h0;
    end else begin
      if (lag_q != 4'hF) lag_q <= lag_q + 4'h1;
      o_clk_ready <= #1 (lag_q >= i_ready_lag);
    end
  end
endmodule // tesc_evsys_model
`default_nettype wire

// ==== tb_timer_event_sleep_sync_control.sv ====
`default_nettype none
module tb_timer_event_sleep_sync_control;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'h0, rst_n = 1'h0, stby = 1'h0, rdy, ev, fire = 1'h0;
  tesc_pkg::tesc_cfg_t cfg = '0;
  logic [6:0] wr = 7'h00;
  logic en_val = 1'h0;
  logic [15:0] wdata = 16'h0000;
  logic [1:0] rd_cc = 2'h0;
  logic [3:0] lag = 4'h0;
  logic req, stopped, running;
  logic [15:0] cnt_rd, period_value_reg;
  logic [31:0] cc;
  logic [1:0] flag, bufv, err, oev;
  logic [5:0] busy;
  int error_cnt = 0, comparisons = 0;
  always #5 clk = ~clk;
  tesc_timer tesc_timer_inst (.i_sys_clk(clk), .i_rst_n(rst_n), .i_ce(1'h1), .i_cfg(cfg),
    .i_standby(stby), .i_clk_ready(rdy), .i_event(ev), .i_wr_soft_reset_bit(wr[0]),
    .i_wr_enable(wr[1]), .i_enable_val(en_val), .i_wr_stop_cmd(wr[2]),
    .i_wr_read_sync_command(wr[3]), .i_wr_count(wr[4]), .i_wr_per(wr[5]), .i_wdata(wdata),
    .i_wr_bufv_clr({1'h0, wr[6]}), .i_rd_cc(rd_cc), .o_clk_req(req), .o_stopped(stopped),
    .o_running(running), .o_count_rd(cnt_rd), .o_per(period_value_reg), .o_cc(cc), .o_cc_flag(flag),
    .o_cc_bufv(bufv), .o_err(err), .o_out_event(oev), .o_sync_busy(busy));
  tesc_evsys_model tesc_evsys_model_inst (.i_sys_clk(clk), .i_rst_n(rst_n), .i_clk_req(req),
    .i_fire(fire), .i_ready_lag(lag), .o_event(ev), .o_clk_ready(rdy));
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'h1) begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Strobe bit i of the write bus for one cycle
  task automatic pulse(input int i);
    tick(1);
    wr[i] = 1'h1;
    tick(1);
    wr[i] = 1'h0;
  endtask
  task automatic fire_ev();
    tick(1);
    fire = 1'h1;
    tick(1);
    fire = 1'h0;
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return running;
      1: return req;
      2: return stopped;
      3: return busy == 6'h00;
      default: return flag[0];
    endcase
  endfunction
  // Bounded wait; a hang closes the run
  task automatic wait_for(input int s, input logic v, input string m);
    int n;
    for (n = 0; n < 60 && sig(s) !== v; n++) tick(1);
    chk(sig(s) === v, m);
    if (sig(s) !== v) end_of_test();
  endtask
  // Start action chosen before enabling, so the timer waits for an event
  task automatic enable_start();
    cfg.event_action_select = tesc_pkg::EVA_START;
    en_val = 1'h1;
    pulse(1);
    wait_for(3, 1'h1, "enable sync");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic sc_period();
    wdata = 16'h0123;
    pulse(5);
    chk(busy[5] === 1'h1, "per busy");
    chk(period_value_reg === 16'hFFFF, "per too early");
    wait_for(3, 1'h1, "per sync");
    chk(period_value_reg === 16'h0123, "per value");
  endtask
  task automatic sc_ignored();
    enable_start();
    fire_ev();
    tick(8);
    chk(running === 1'h0 && stopped === 1'h1, "event not ignored");
  endtask
  task automatic sc_on_demand();
    int n;
    cfg.input_event_enable = 1'h1;
    cfg.clock_on_demand = 1'h1;
    lag = 4'h6;
    fire_ev();
    wait_for(1, 1'h1, "no clock request");
    for (n = 0; n < 20 && rdy !== 1'h1; n++) begin
      chk(running === 1'h0, "ran before clock");
      tick(1);
    end
    wait_for(0, 1'h1, "not running");
    pulse(2);
    wait_for(2, 1'h1, "stop");
    wait_for(1, 1'h0, "request held while stopped");
  endtask
  task automatic sc_capture();
    int n, seen;
    lag = 4'h0;
    fire_ev();
    wait_for(0, 1'h1, "restart");
    cfg.event_action_select = tesc_pkg::EVA_STAMP;
    cfg.channel_output_event_enable = 2'h1;
    fire = 1'h1;
    seen = 0;
    for (n = 0; n < 8; n++) begin
      tick(1);
      fire = 1'h0;
      if (oev[0] === 1'h1) seen++;
      chk(oev[1] === 1'h0, "masked event out");
    end
    chk(seen == 1, "channel event out");
    wait_for(4, 1'h1, "capture flag");
    fire_ev();
    tick(4);
    chk(bufv[0] === 1'h1, "buffered capture");
    fire_ev();
    tick(4);
    chk(err[0] === 1'h1, "overflow error");
    rd_cc = 2'h1;
    tick(1);
    rd_cc = 2'h0;
    tick(3);
    chk(bufv[0] === 1'h0 && flag[0] === 1'h1, "buffer to value");
    fire_ev();
    tick(4);
    pulse(6);
    chk(bufv[0] === 1'h1, "buffer clear too early");
    tick(2);
    chk(bufv[0] === 1'h0 && flag[0] === 1'h1, "buffer valid clear");
    pulse(3);
    wait_for(3, 1'h1, "read_sync_command");
    chk(cnt_rd !== 16'h0000, "count copy");
    stby = 1'h1;
    wait_for(0, 1'h0, "ran in standby");
    stby = 1'h0;
  endtask
  task automatic sc_soft_reset_bit();
    pulse(0);
    chk(busy[0] === 1'h1, "soft_reset_bit busy");
    wait_for(3, 1'h1, "soft_reset_bit sync");
    chk(period_value_reg === 16'hFFFF && flag === 2'h0 && err === 2'h0, "soft reset");
    enable_start();
    fire_ev();
    wait_for(0, 1'h1, "restart after reset");
    cfg.event_action_select = tesc_pkg::EVA_PPW;
    fire_ev();
    tick(3);
    fire_ev();
    tick(4);
    chk(flag === 2'h3, "period and width");
  endtask
  initial begin
    tick(16);
    rst_n = 1'h1;
    tick(1);
    // On-demand is off, so the clock is wanted from the first edge
    chk(stopped === 1'h1 && running === 1'h0 && req === 1'h1 && period_value_reg === 16'hFFFF,
        "reset state");
    sc_period();
    sc_ignored();
    sc_on_demand();
    sc_capture();
    sc_soft_reset_bit();
    end_of_test();
  end
endmodule // tb_timer_event_sleep_sync_control
`default_nettype wire
